//--- hdl/adc_clock_sysref_cal_ctrl.sv
// How it works
// - Sample clock is input divided 1,2,4,8.
// - Divide write restarts serial link init.
// - SYSREF passes through gate enable AND.
// - Closed gate leaves frame alignment unchanged.
// - Gate closed after reset.
// - Offset and gate enables are writable.
// - Half input-period steps, 2xdivide positions.
// - One phase setting for both channels.
// - Phase change leaves link clocks undisturbed.
// - Phase change shifts only sampling latency.
// - Divided clock realigns on accepted SYSREF.
// - Swing and de-emphasis, eight codes each.
// - Wait 8.4M cycles then auto calibrate.
// - Calibration lasts about 2.0M cycles.
// - Power-down then normal triggers recalibration.
`timescale 1ns/10ps
module adc_clock_sysref_cal_ctrl #(
  parameter int PWRUP_CYC = clk_cal_pkg::PWRUP_DELAY_CYC,
  parameter int CALIB_CYC = clk_cal_pkg::CAL_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings written by software
  input wire logic [clk_cal_pkg::DIV_W-1:0] clock_divide_factor,
  input wire logic clock_divide_wr,
  input wire logic [clk_cal_pkg::PHASE_W-1:0] phase_setting,
  input wire logic sysref_gate_en,
  input wire logic sysref_offset_en,
  input wire logic [clk_cal_pkg::DRV_W-1:0] driver_swing_setting,
  input wire logic [clk_cal_pkg::DRV_W-1:0] driver_deemphasis_setting,
  input wire logic drv_wr,
  input wire logic power_down,
  // Device condition and link side
  input wire logic supplies_clock_valid,
  input wire logic sysref_in,
  // Status and controls out
  output logic sample_tick,
  output logic [clk_cal_pkg::DIV_W-1:0] div_active,
  output logic [clk_cal_pkg::PHASE_W-1:0] phase_active,
  output logic sysref_accepted,
  output logic sysref_offset_active,
  output logic link_reinit,
  output logic [clk_cal_pkg::DRV_W-1:0] swing_active,
  output logic [clk_cal_pkg::DRV_W-1:0] deemph_active,
  output logic cal_busy,
  output logic cal_done
);
  import clk_cal_pkg::*;

  localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(PWRUP_CYC - 1);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CALIB_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Settings and SYSREF gate.

  sample_clk_if sif ();

  logic [DIV_W-1:0] div_ff;
  logic [PHASE_W-1:0] phase_ff;
  logic gate_ff;
  logic offset_ff;
  logic sysref_d_ff;
  logic sysref_rise;
  logic sysref_evt_ff;
  logic [2:0] reinit_cnt_ff;
  logic [DRV_W-1:0] swing_ff;
  logic [DRV_W-1:0] deemph_ff;
  logic [PHASE_W-1:0] phase_mask;

  // The reported phase is the position actually applied at the current divide factor.
  assign phase_mask = PHASE_W'((5'h02 << div_ff) - 5'h01);
  // Edges are ignored unless the gate is open, so frame alignment holds.
  assign sysref_rise = sysref_in & ~sysref_d_ff & gate_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= DIV_RST;
      gate_ff <= 1'b0;
      offset_ff <= 1'b0;
      sysref_d_ff <= 1'b0;
      sysref_evt_ff <= 1'b0;
      phase_ff <= PHASE_RST;
      swing_ff <= SWING_RST;
      deemph_ff <= DEEMPH_RST;
    end else begin
      if (clock_divide_wr) begin
        div_ff <= clock_divide_factor;
      end
      gate_ff <= sysref_gate_en;
      offset_ff <= sysref_offset_en;
      sysref_d_ff <= sysref_in;
      sysref_evt_ff <= sysref_rise;
      // Phase moves only the sampling tick; link timing is not touched.
      phase_ff <= phase_setting;
      if (drv_wr) begin
        swing_ff <= driver_swing_setting;
        deemph_ff <= driver_deemphasis_setting;
      end
    end
  end

  // A pulse of a few cycles makes the link restart unmistakable downstream.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reinit_cnt_ff <= 3'h0;
    end else if (clock_divide_wr) begin
      reinit_cnt_ff <= 3'(RELINK_CYC);
    end else if (reinit_cnt_ff != 3'h0) begin
      reinit_cnt_ff <= reinit_cnt_ff - 3'h1;
    end
  end

  assign sif.div_code = div_ff;
  assign sif.sysref_evt = sysref_evt_ff;
  assign sif.phase = phase_ff;

  sample_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer, counting sampling clock ticks.

  cal_state_e state_ff;
  cal_state_e nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic pd_seen_ff;
  logic done_ff;
  logic cnt_last;
  logic start_manual;

  // Deliberate power-down and return is the manual calibration request.
  assign start_manual = pd_seen_ff & ~power_down;
  assign cnt_last = (state_ff == ST_PWRUP_DELAY) ? (cnt_ff == PWRUP_LAST) : (cnt_ff == CAL_LAST);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_WAIT_VALID: if (supplies_clock_valid) nxt_state = ST_PWRUP_DELAY;
      ST_PWRUP_DELAY: if (sif.sample_tick && cnt_last) nxt_state = ST_CALIBRATE;
      ST_CALIBRATE: if (sif.sample_tick && cnt_last) nxt_state = ST_IDLE;
      ST_IDLE: if (start_manual) nxt_state = ST_CALIBRATE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_WAIT_VALID;
      cnt_ff <= '0;
      pd_seen_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        cnt_ff <= '0;
      end else if (sif.sample_tick) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      if (power_down) begin
        pd_seen_ff <= 1'b1;
      end else if (state_ff == ST_IDLE) begin
        pd_seen_ff <= 1'b0;
      end
      // Completion sets the flag; entering calibration clears it.
      if (state_ff == ST_CALIBRATE && nxt_state == ST_IDLE) begin
        done_ff <= 1'b1;
      end else if (nxt_state == ST_CALIBRATE) begin
        done_ff <= 1'b0;
      end
    end
  end

  property p_done_clear;
    @(posedge clk) disable iff (rst) (state_ff == ST_CALIBRATE) |-> !done_ff;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done set during cal");

  property p_done_set;
    @(posedge clk) disable iff (rst)
      (state_ff == ST_CALIBRATE && sif.sample_tick && cnt_last) |=> done_ff;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set at end");

  property p_gate;
    @(posedge clk) disable iff (rst) !gate_ff |=> !sysref_evt_ff;
  endproperty
  a_gate: assert property (p_gate) else $error("sysref passed closed gate");

  property p_reinit;
    @(posedge clk) disable iff (rst) clock_divide_wr |=> (reinit_cnt_ff != 3'h0)[*3];
  endproperty
  a_reinit: assert property (p_reinit) else $error("no link reinit");

  property p_delay;
    @(posedge clk) disable iff (rst)
      (state_ff == ST_PWRUP_DELAY) && !(sif.sample_tick && cnt_last) |=> state_ff != ST_CALIBRATE;
  endproperty
  a_delay: assert property (p_delay) else $error("cal started early");

  property p_manual;
    @(posedge clk) disable iff (rst) (state_ff == ST_IDLE && start_manual) |=> state_ff == ST_CALIBRATE;
  endproperty
  a_manual: assert property (p_manual) else $error("manual cal missed");

  property p_swing;
    @(posedge clk) disable iff (rst) drv_wr |=> swing_ff == $past(driver_swing_setting);
  endproperty
  a_swing: assert property (p_swing) else $error("swing not loaded");

  property p_divload;
    @(posedge clk) disable iff (rst) clock_divide_wr |=> div_ff == $past(clock_divide_factor);
  endproperty
  a_divload: assert property (p_divload) else $error("divide not loaded");

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_tick <= 1'b0;
      div_active <= DIV_RST;
      phase_active <= PHASE_RST;
      sysref_accepted <= 1'b0;
      sysref_offset_active <= 1'b0;
      link_reinit <= 1'b0;
      swing_active <= SWING_RST;
      deemph_active <= DEEMPH_RST;
      cal_busy <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      sample_tick <= sif.sample_tick;
      div_active <= div_ff;
      phase_active <= phase_ff & phase_mask;
      sysref_accepted <= sysref_evt_ff;
      sysref_offset_active <= offset_ff;
      link_reinit <= (reinit_cnt_ff != 3'h0);
      swing_active <= swing_ff;
      deemph_active <= deemph_ff;
      cal_busy <= (state_ff == ST_CALIBRATE);
      cal_done <= done_ff;
    end
  end
endmodule // adc_clock_sysref_cal_ctrl

//--- hdl/clk_cal_pkg.sv
package clk_cal_pkg;
  // Divide codes: 0 -> /1, 1 -> /2, 2 -> /4, 3 -> /8.
  localparam int DIV_W = 2;
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam int PHASE_W = 4;
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam int DRV_W = 3;
  localparam logic [2:0] SWING_RST = 3'h0;
  localparam logic [2:0] DEEMPH_RST = 3'h0;
  // Power-up and calibration counts are in sampling clock cycles; RELINK_CYC is in clk cycles, each one input-clock half period.
  localparam int PWRUP_DELAY_CYC = 8400000;
  localparam int CAL_CYC = 2000000;
  localparam int CNT_W = 24;
  localparam int RELINK_CYC = 4;
  typedef enum logic [1:0] {
    ST_WAIT_VALID,
    ST_PWRUP_DELAY,
    ST_CALIBRATE,
    ST_IDLE
  } cal_state_e;
endpackage

//--- hdl/sample_clk_div.sv
`timescale 1ns/10ps
module sample_clk_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divider control
  sample_clk_if.div sif
);
  import clk_cal_pkg::*;

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [4:0] half_periods;
  logic [3:0] last_cnt;
  logic tick_ff;
  logic [3:0] nxt_sel;

  // Count runs in input-clock half periods; /1 still has two positions.
  // Five bits are needed here because /8 gives sixteen positions.
  assign half_periods = 5'h02 << sif.div_code;
  assign last_cnt = 4'(half_periods - 5'h01);
  assign nxt_sel = sif.phase & last_cnt;
  // A SYSREF event restarts the divider phase.
  assign nxt_cnt = sif.sysref_evt ? 4'h0 : (cnt_ff >= last_cnt ? 4'h0 : cnt_ff + 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= (nxt_cnt == nxt_sel);
    end
  end

  assign sif.sample_tick = tick_ff;

  property p_realign;
    @(posedge clk) disable iff (rst) sif.sysref_evt |=> (cnt_ff == 4'h0);
  endproperty
  a_realign: assert property (p_realign) else $error("divider not realigned");

  property p_range;
    @(posedge clk) disable iff (rst) cnt_ff <= last_cnt || $changed(sif.div_code);
  endproperty
  a_range: assert property (p_range) else $error("divider count out of range");
endmodule // sample_clk_div

//--- hdl/sample_clk_if.sv
`timescale 1ns/10ps
interface sample_clk_if;
  logic [1:0] div_code;
  logic sysref_evt;
  logic [3:0] phase;
  logic sample_tick;
  modport ctrl (output div_code, output sysref_evt, output phase, input sample_tick);
  modport div (input div_code, input sysref_evt, input phase, output sample_tick);
endinterface

//--- tb/sysref_src.sv
`timescale 1ns/10ps
module sysref_src (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic fire,
  // Toward the device
  output logic sysref_in
);
  // Launched by a non-blocking update on the rising edge, so the bench's falling-edge
  // request is settled when it is taken and the device sees no race.
  initial sysref_in = 1'b0;
  always @(posedge clk) begin
    sysref_in <= fire;
  end
endmodule // sysref_src

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import clk_cal_pkg::*;
  localparam int PW = 20;
  localparam int CC = 10;
  logic clk, rst, clock_divide_wr, sysref_gate_en, sysref_offset_en, drv_wr, power_down;
  logic supplies_clock_valid, sysref_in, fire, sample_tick, sysref_accepted;
  logic sysref_offset_active, link_reinit, cal_busy, cal_done;
  logic [DIV_W-1:0] clock_divide_factor, div_active;
  logic [PHASE_W-1:0] phase_setting, phase_active;
  logic [DRV_W-1:0] driver_swing_setting, driver_deemphasis_setting, swing_active, deemph_active;
  int err_total, cmp_count, lfsr, per, n;
  adc_clock_sysref_cal_ctrl #(.PWRUP_CYC(PW), .CALIB_CYC(CC)) i_dut (.clk, .rst,
    .clock_divide_factor, .clock_divide_wr, .phase_setting, .sysref_gate_en,
    .sysref_offset_en, .driver_swing_setting, .driver_deemphasis_setting, .drv_wr,
    .power_down, .supplies_clock_valid, .sysref_in, .sample_tick, .div_active,
    .phase_active, .sysref_accepted, .sysref_offset_active, .link_reinit, .swing_active,
    .deemph_active, .cal_busy, .cal_done);
  sysref_src i_src (.clk, .fire, .sysref_in);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic int nxt(int v);
    return ((v << 1) | (v[7] ^ v[5] ^ v[4] ^ v[3])) & 255;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chkv(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t value %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic gap(output int g);
    n = 0;
    while (sample_tick !== 1'b1 && n < 64) begin
      cyc(1);
      n++;
    end
    g = 0;
    do begin
      cyc(1);
      g++;
    end while (sample_tick !== 1'b1 && g < 64);
  endtask
  task automatic acc(output int c);
    c = 0;
    repeat (8) begin
      cyc(1);
      c += (sysref_accepted === 1'b1);
    end
  endtask
  task automatic wdone(input int lo, input int hi);
    n = 0;
    while (cal_done !== 1'b1 && n < 999) begin
      chk1(cal_done, 1'b0);
      cyc(1);
      n++;
    end
    chk1(n >= lo && n <= hi, 1'b1);
    chk1(cal_busy, 1'b0);
  endtask
  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The whole sequence needs well under 2000 cycles.
  initial begin
    #50000;
    err_total++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    {clock_divide_wr, sysref_gate_en, sysref_offset_en, drv_wr, power_down} = '0;
    {supplies_clock_valid, fire, clock_divide_factor, phase_setting} = '0;
    {driver_swing_setting, driver_deemphasis_setting} = '0;
    lfsr = 43;
    err_total = 0;
    cmp_count = 0;
    cyc(5);
    chk1(sysref_accepted, 1'b0);
    chk1(cal_done, 1'b0);
    rst = 1'b0;
    for (int d = 3; d >= 0; d--) begin
      clock_divide_factor = d[1:0];
      clock_divide_wr = 1'b1;
      cyc(1);
      clock_divide_wr = 1'b0;
      cyc(1);
      chkv(div_active, d[4:0]);
      repeat (4) begin
        chk1(link_reinit, 1'b1);
        cyc(1);
      end
      chk1(link_reinit, 1'b0);
      gap(per);
      chkv(per[4:0], 5'(2 << d));
      phase_setting = lfsr[3:0];
      cyc(3);
      chkv(phase_active, 5'(lfsr[3:0] & ((2 << d) - 1)));
      chk1(link_reinit, 1'b0);
      lfsr = nxt(lfsr);
    end
    for (int k = 0; k < 8; k++) begin
      driver_swing_setting = k[2:0];
      driver_deemphasis_setting = lfsr[2:0];
      drv_wr = 1'b1;
      cyc(1);
      drv_wr = 1'b0;
      cyc(2);
      chkv(swing_active, k[4:0]);
      chkv(deemph_active, 5'(lfsr[2:0]));
      lfsr = nxt(lfsr);
    end
    sysref_offset_en = 1'b1;
    cyc(2);
    chk1(sysref_offset_active, 1'b1);
    sysref_offset_en = 1'b0;
    cyc(2);
    chk1(sysref_offset_active, 1'b0);
    fire = 1'b1;
    cyc(2);
    fire = 1'b0;
    acc(n);
    chkv(n[4:0], 5'h0);
    sysref_gate_en = 1'b1;
    cyc(2);
    fire = 1'b1;
    cyc(2);
    fire = 1'b0;
    acc(n);
    chkv(n[4:0], 5'h1);
    // Power-up calibration runs at divide by one, two cycles per sample tick.
    supplies_clock_valid = 1'b1;
    n = 0;
    while (cal_busy !== 1'b1 && n < 999) begin
      cyc(1);
      n++;
    end
    chk1(n >= 2 * PW - 2 && n <= 2 * PW + 8, 1'b1);
    wdone(2 * CC - 4, 2 * CC + 8);
    // After a new divide factor software recalibrates by power-down and back.
    clock_divide_factor = 2'h1;
    clock_divide_wr = 1'b1;
    cyc(1);
    clock_divide_wr = 1'b0;
    cyc(8);
    power_down = 1'b1;
    cyc(2);
    power_down = 1'b0;
    cyc(4);
    chk1(cal_busy, 1'b1);
    chk1(cal_done, 1'b0);
    wdone(4 * CC - 12, 4 * CC + 8);
    give_verdict();
  end
endmodule // tb
